// ==== design/rxlog_fifo.sv ====
// How it works
// - Every received word, queued or not, sets its block's four scheduler freshness bits, and scheduler k clears bit k by reading that block.
// - A one-kilobyte region holds the eight channel log queues, one per receive channel.
// - Each channel queue holds up to thirty-two 32-bit words.
// - Software fills a channel-by-label bitmap with ones to pick which words are queued.
// - A received word whose channel and label bit is one is appended to that channel's queue.
// - The host drains queued words only through dedicated pop reads, which return the oldest word.
// - Not-empty, threshold and full status each keep one bit per channel showing its present state.
// - After reset all queues are empty and all three status registers read zero.
// - Appending a word to a queue sets that channel's not-empty bit.
// - The threshold bit is set while a queue holds strictly more words than the threshold value.
// - The full bit is set once a queue holds thirty-two words.
// - A full queue still stores a new word and drops its oldest one.
// - A two-bit field per channel picks not-empty, threshold or full as the channel's flag source.
// - A pop colliding with an append on the same channel loses no word.
// - Bit n of the not-empty register belongs to channel n.
//
// The implementer's own choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
module rxlog_fifo (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone register slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    // received word link, all asynchronous
    input wire logic lnk_clk_i,
    input wire logic rx_valid_i,
    input wire logic [2:0] rx_ch_i,
    input wire logic [31:0] rx_word_i,
    // transmit scheduler freshness port
    input wire logic [3:0] sched_rd_i,
    input wire logic [10:0] sched_addr_i,
    output logic sched0_fresh_word_o,
    output logic sched1_fresh_word_o,
    output logic sched2_fresh_word_o,
    output logic sched3_fresh_word_o,
    // interrupt
    output logic irq_o
);
    localparam int CH = rxlog_pkg::CHANNELS;
    localparam int SYNC_W = 2 + rxlog_pkg::CH_W + rxlog_pkg::WORD_W;

    // byte enables to a bit mask
    function automatic logic [31:0] byte_mask(input logic [3:0] sel);
        logic [31:0] m;
        m = '0;
        for (int b = 0; b < 4; b++) begin
            m[8*b +: 8] = {8{sel[b]}};
        end
        return m;
    endfunction

    // pick one status flag by the two-bit source code
    function automatic logic flag_pick(input logic [1:0] sel, input logic ne,
                                       input logic th, input logic full);
        logic f;
        case (rxlog_pkg::flag_sel_t'(sel))
            rxlog_pkg::FFS_NOT_EMPTY: f = ne;
            rxlog_pkg::FFS_THRESH: f = th;
            rxlog_pkg::FFS_FULL: f = full;
            default: f = 1'b0;
        endcase
        return f;
    endfunction

    rxlog_pkg::mode_t mode_r;
    logic [rxlog_pkg::LUT_AW-1:0] sweep_r;
    logic [rxlog_pkg::CNT_W-1:0] cnt_r [CH];
    logic [rxlog_pkg::PTR_W-1:0] wr_ptr_r [CH];
    logic [rxlog_pkg::PTR_W-1:0] rd_ptr_r [CH];
    logic [CH-1:0] ne_r, th_r, full_r, mux_r, ist_r, imask_r;
    logic [CH-1:0] ne_c, th_c, full_c, mux_c;
    logic [7:0] thr_r;
    logic [rxlog_pkg::FLAG_SEL_W-1:0] fsel_r;
    logic [SYNC_W-1:0] sync_q;
    logic lnk_prev_r, rx_edge;
    logic [rxlog_pkg::WORD_W-1:0] cap_word_r;
    logic [rxlog_pkg::CH_W-1:0] cap_ch_r;
    logic cap_v_r, lut_bit, app_v;
    logic [rxlog_pkg::LUT_AW-1:0] rx_key;
    logic take, pend_r, pop_v, pop_hit_r;
    logic [7:0] req_adr_r;
    logic [rxlog_pkg::CH_W-1:0] pop_ch;
    logic [31:0] wmask, fifo_rd;
    logic lut_we, lut_wval;
    logic [rxlog_pkg::LUT_AW-1:0] lut_waddr;
    logic fr_we;
    logic [rxlog_pkg::LUT_AW-1:0] fr_addr, clr_addr_r;
    logic [rxlog_pkg::SCHEDS-1:0] fr_data, fr_mask, clr_mask_r, fr_rd;
    logic clr_pend_r, sweeping, ist_wr;

    // link inputs cross into the clock domain
    rxlog_sync #(.WIDTH(SYNC_W)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({lnk_clk_i, rx_valid_i, rx_ch_i, rx_word_i}),
        .q_o(sync_q)
    );

    // rising link edge with a valid word marks an arrival
    assign sweeping = (mode_r == rxlog_pkg::ST_SWEEP);
    assign rx_edge = sync_q[SYNC_W-1] & ~lnk_prev_r & sync_q[SYNC_W-2] & ~sweeping;
    assign rx_key = {sync_q[rxlog_pkg::WORD_W +: rxlog_pkg::CH_W],
                     sync_q[rxlog_pkg::LABEL_W-1:0]};

    // bring-up sweep clears bitmap and freshness bits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_r <= rxlog_pkg::ST_SWEEP;
            sweep_r <= '0;
        end else begin
            case (mode_r)
                rxlog_pkg::ST_SWEEP: begin
                    sweep_r <= sweep_r + 1'b1;
                    if (sweep_r == rxlog_pkg::LUT_LAST) begin
                        mode_r <= rxlog_pkg::ST_RUN;
                    end
                end
                rxlog_pkg::ST_RUN: mode_r <= rxlog_pkg::ST_RUN;
                default: mode_r <= rxlog_pkg::ST_SWEEP;
            endcase
        end
    end

    // capture the arriving word while its bitmap bit is read
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lnk_prev_r <= 1'b0;
            cap_v_r <= 1'b0;
            cap_word_r <= '0;
            cap_ch_r <= '0;
        end else begin
            lnk_prev_r <= sync_q[SYNC_W-1];
            cap_v_r <= rx_edge;
            if (rx_edge) begin
                cap_word_r <= sync_q[rxlog_pkg::WORD_W-1:0];
                cap_ch_r <= sync_q[rxlog_pkg::WORD_W +: rxlog_pkg::CH_W];
            end
        end
    end

    assign lut_we = sweeping | (take & wb_we_i & (wb_adr_i == rxlog_pkg::REG_LUT_WRITE)
                                & wb_sel_i[0]);
    assign lut_waddr = sweeping ? sweep_r : {wb_dat_i[rxlog_pkg::LUT_CH_LSB +: rxlog_pkg::CH_W],
                                             wb_dat_i[rxlog_pkg::LUT_LABEL_LSB +: rxlog_pkg::LABEL_W]};
    assign lut_wval = ~sweeping & wb_dat_i[rxlog_pkg::LUT_VAL_BIT];

    rxlog_ram #(.WIDTH(1), .AW(rxlog_pkg::LUT_AW)) u_lut (
        .clk_i(clk_i),
        .we_i(lut_we),
        .wr_addr_i(lut_waddr),
        .wr_data_i(lut_wval),
        .wr_mask_i(1'b1),
        .rd_addr_i(rx_key),
        .rd_data_o(lut_bit)
    );

    // accepted words go to their channel queue
    assign app_v = cap_v_r & lut_bit;

    // one word-wide store covers the whole log region
    rxlog_ram #(.WIDTH(rxlog_pkg::WORD_W), .AW(rxlog_pkg::FIFO_AW)) u_log (
        .clk_i(clk_i),
        .we_i(app_v),
        .wr_addr_i({cap_ch_r, wr_ptr_r[cap_ch_r]}),
        .wr_data_i(cap_word_r),
        .wr_mask_i('1),
        .rd_addr_i({pop_ch, rd_ptr_r[pop_ch]}),
        .rd_data_o(fifo_rd)
    );

    // freshness write port, a new word wins over a clear
    always_comb begin
        fr_we = 1'b1;
        fr_addr = clr_addr_r;
        fr_data = rxlog_pkg::FRESH_NONE;
        fr_mask = clr_mask_r;
        if (sweeping) begin
            fr_addr = sweep_r;
            fr_mask = rxlog_pkg::FRESH_ALL;
        end else if (rx_edge) begin
            fr_addr = rx_key;
            fr_data = rxlog_pkg::FRESH_ALL;
            fr_mask = rxlog_pkg::FRESH_ALL;
        end else if (!clr_pend_r) begin
            fr_we = |sched_rd_i;
            fr_addr = sched_addr_i;
            fr_mask = sched_rd_i;
        end
    end

    // a clear blocked by a new word or a waiting clear waits one cycle, one blocked by the sweep waits for its end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clr_pend_r <= 1'b0;
            clr_addr_r <= '0;
            clr_mask_r <= '0;
        end else if (|sched_rd_i && (sweeping || rx_edge || clr_pend_r)
                     && !(rx_edge && sched_addr_i == rx_key)) begin
            clr_pend_r <= 1'b1;
            clr_addr_r <= sched_addr_i;
            clr_mask_r <= sched_rd_i;
        end else if (rx_edge && clr_addr_r == rx_key) begin
            // newer word on the waiting block, its set wins
            clr_pend_r <= 1'b0;
        end else if (!sweeping && !rx_edge) begin
            clr_pend_r <= 1'b0;
        end
    end

    rxlog_ram #(.WIDTH(rxlog_pkg::SCHEDS), .AW(rxlog_pkg::LUT_AW)) u_fresh (
        .clk_i(clk_i),
        .we_i(fr_we),
        .wr_addr_i(fr_addr),
        .wr_data_i(fr_data),
        .wr_mask_i(fr_mask),
        .rd_addr_i(sched_addr_i),
        .rd_data_o(fr_rd)
    );
    assign {sched3_fresh_word_o, sched2_fresh_word_o,
            sched1_fresh_word_o, sched0_fresh_word_o} = fr_rd;

    // bus request taken once, answered two edges later
    assign take = wb_cyc_i & wb_stb_i & ~pend_r & ~wb_ack_o & ~sweeping;
    assign wmask = byte_mask(wb_sel_i);
    assign pop_ch = wb_adr_i[rxlog_pkg::POP_CH_LSB +: rxlog_pkg::CH_W];
    // pop reads are the only bus access that takes a word out of a queue
    assign pop_v = take & ~wb_we_i
                   & ((wb_adr_i & rxlog_pkg::REG_POP_MASK) == rxlog_pkg::REG_POP_BASE);

    // pointers and fill count per channel
    always_ff @(posedge clk_i) begin
        for (int c = 0; c < CH; c++) begin
            if (rst_i) begin
                cnt_r[c] <= rxlog_pkg::EMPTY_CNT;
                wr_ptr_r[c] <= '0;
                rd_ptr_r[c] <= '0;
            end else begin
                automatic logic inc = app_v && (cap_ch_r == c);
                automatic logic dec = pop_v && (pop_ch == c)
                                      && (cnt_r[c] != rxlog_pkg::EMPTY_CNT);
                if (inc) begin
                    wr_ptr_r[c] <= wr_ptr_r[c] + 1'b1;
                end
                if (dec || (inc && cnt_r[c] == rxlog_pkg::FULL_CNT)) begin
                    rd_ptr_r[c] <= rd_ptr_r[c] + 1'b1;
                end
                if (inc && !dec && cnt_r[c] != rxlog_pkg::FULL_CNT) begin
                    cnt_r[c] <= cnt_r[c] + 1'b1;
                end else if (dec && !inc) begin
                    cnt_r[c] <= cnt_r[c] - 1'b1;
                end
            end
        end
    end

    always_comb begin
        for (int c = 0; c < CH; c++) begin
            ne_c[c] = (cnt_r[c] != rxlog_pkg::EMPTY_CNT);
            th_c[c] = ({2'h0, cnt_r[c]} > thr_r);
            full_c[c] = (cnt_r[c] == rxlog_pkg::FULL_CNT);
            mux_c[c] = flag_pick(fsel_r[2*c +: 2], ne_c[c], th_c[c], full_c[c]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ne_r <= rxlog_pkg::FLAGS_RST;
            th_r <= rxlog_pkg::FLAGS_RST;
            full_r <= rxlog_pkg::FLAGS_RST;
            mux_r <= rxlog_pkg::FLAGS_RST;
        end else begin
            ne_r <= ne_c;
            th_r <= th_c;
            full_r <= full_c;
            mux_r <= mux_c;
        end
    end

    // control registers written by software
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            thr_r <= rxlog_pkg::THRESH_VAL_RST;
            fsel_r <= rxlog_pkg::FLAG_SEL_RST;
            imask_r <= rxlog_pkg::FLAGS_RST;
        end else if (take && wb_we_i) begin
            if (wb_adr_i == rxlog_pkg::REG_THRESH_VAL) begin
                thr_r <= (thr_r & ~wmask[7:0]) | (wb_dat_i[7:0] & wmask[7:0]);
            end
            if (wb_adr_i == rxlog_pkg::REG_FLAG_SEL) begin
                fsel_r <= (fsel_r & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
            end
            if (wb_adr_i == rxlog_pkg::REG_INT_MASK) begin
                imask_r <= (imask_r & ~wmask[7:0]) | (wb_dat_i[7:0] & wmask[7:0]);
            end
        end
    end

    // sticky flag events, write one to clear, a new event wins
    assign ist_wr = take & wb_we_i & (wb_adr_i == rxlog_pkg::REG_INT_STATUS);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ist_r <= rxlog_pkg::FLAGS_RST;
            irq_o <= 1'b0;
        end else begin
            ist_r <= (ist_r & ~(ist_wr ? wb_dat_i[7:0] & wmask[7:0] : 8'h00))
                     | (mux_c & ~mux_r);
            irq_o <= |(ist_r & imask_r);
        end
    end

    // bus answer: latch the request, then ack with read data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_r <= 1'b0;
            wb_ack_o <= 1'b0;
            req_adr_r <= '0;
            pop_hit_r <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            pend_r <= take;
            wb_ack_o <= pend_r;
            if (take) begin
                req_adr_r <= wb_we_i ? rxlog_pkg::REG_LUT_WRITE : wb_adr_i;
                pop_hit_r <= pop_v && (cnt_r[pop_ch] != rxlog_pkg::EMPTY_CNT);
            end
            if (pend_r) begin
                case (req_adr_r)
                    rxlog_pkg::REG_NOT_EMPTY: wb_dat_o <= 32'(ne_r);
                    rxlog_pkg::REG_THRESH_FLAG: wb_dat_o <= 32'(th_r);
                    rxlog_pkg::REG_FULL: wb_dat_o <= 32'(full_r);
                    rxlog_pkg::REG_MUX_FLAG: wb_dat_o <= 32'(mux_r);
                    rxlog_pkg::REG_THRESH_VAL: wb_dat_o <= 32'(thr_r);
                    rxlog_pkg::REG_FLAG_SEL: wb_dat_o <= 32'(fsel_r);
                    rxlog_pkg::REG_INT_STATUS: wb_dat_o <= 32'(ist_r);
                    rxlog_pkg::REG_INT_MASK: wb_dat_o <= 32'(imask_r);
                    default: wb_dat_o <= pop_hit_r ? fifo_rd : 32'h0000_0000;
                endcase
            end else begin
                wb_dat_o <= '0;
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_word_taken;
        rx_edge ##1 lut_bit;
    endsequence

    sequence s_full_push;
        app_v && full_c[cap_ch_r] && !pop_v;
    endsequence

    a_reset_clear: assert property (
        @(posedge clk_i) disable iff (1'b0)
        $past(rst_i) |-> (ne_r == 8'h00 && th_r == 8'h00 && full_r == 8'h00))
        else $error("status not clear after reset");

    a_append_sets_ne: assert property (
        s_word_taken |=> ##1 ne_r[cap_ch_r])
        else $error("append did not set not-empty");

    a_overwrite_keep: assert property (
        s_full_push |=> cnt_r[$past(cap_ch_r)] == rxlog_pkg::FULL_CNT ##1 full_r[cap_ch_r])
        else $error("full queue lost its count on overwrite");

    a_count_bound: assert property (
        cnt_r[cap_ch_r] <= rxlog_pkg::FULL_CNT && cnt_r[pop_ch] <= rxlog_pkg::FULL_CNT
        && (full_r & ~ne_r) == 8'h00)
        else $error("queue count out of range");

    a_thresh_flag: assert property (
        $stable(cap_ch_r) && $rose(th_r[cap_ch_r])
        |-> $past({2'h0, cnt_r[cap_ch_r]}) > $past(thr_r))
        else $error("threshold flag set too early");

    a_fresh_set: assert property (
        rx_edge |-> fr_we && fr_mask == rxlog_pkg::FRESH_ALL && fr_data == rxlog_pkg::FRESH_ALL)
        else $error("new word did not set freshness bits");

    a_pop_count: assert property (
        pop_v && ne_c[pop_ch] && !app_v |=> cnt_r[$past(pop_ch)] == $past(cnt_r[pop_ch]) - 1'b1)
        else $error("pop did not lower the count");

    a_ack_timing: assert property (
        take |=> !wb_ack_o ##1 wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer not two edges after request");

    a_flag_select: assert property (
        fsel_r[2*cap_ch_r +: 2] == rxlog_pkg::FFS_FULL && $stable(fsel_r) && $stable(cap_ch_r)
        |-> mux_r[cap_ch_r] == $past(full_c[cap_ch_r]))
        else $error("muxed flag ignores its source select");

    a_no_loss: assert property (
        app_v && pop_v && pop_ch == cap_ch_r && ne_c[pop_ch]
        |=> cnt_r[$past(pop_ch)] == $past(cnt_r[pop_ch]))
        else $error("collision changed the count");
endmodule
`default_nettype wire

// ==== design/rxlog_pkg.sv ====
package rxlog_pkg;
    // channel and word geometry
    localparam int CHANNELS = 8;
    localparam int CH_W = 3;
    localparam int DEPTH = 32;
    localparam int PTR_W = 5;
    localparam int CNT_W = 6;
    localparam int WORD_W = 32;
    localparam int LABEL_W = 8;
    localparam int SCHEDS = 4;
    localparam logic [CNT_W-1:0] FULL_CNT = 6'h20;
    localparam logic [CNT_W-1:0] EMPTY_CNT = 6'h00;

    // reserved log region, byte wide in the device map
    localparam logic [15:0] FIFO_REGION_FIRST = 16'h3000;
    localparam logic [15:0] FIFO_REGION_LAST = 16'h33ff;
    localparam int FIFO_REGION_BYTES = 1024;
    localparam int FIFO_AW = $clog2(FIFO_REGION_BYTES / (WORD_W / 8));
    // acceptance bitmap, one bit per channel and label
    localparam logic [15:0] LUT_REGION_FIRST = 16'h7a00;
    localparam int LUT_AW = CH_W + LABEL_W;
    localparam logic [LUT_AW-1:0] LUT_LAST = 11'h7ff;

    // register byte offsets
    localparam logic [7:0] REG_NOT_EMPTY = 8'h00;
    localparam logic [7:0] REG_THRESH_FLAG = 8'h04;
    localparam logic [7:0] REG_FULL = 8'h08;
    localparam logic [7:0] REG_MUX_FLAG = 8'h0c;
    localparam logic [7:0] REG_THRESH_VAL = 8'h10;
    localparam logic [7:0] REG_FLAG_SEL = 8'h14;
    localparam logic [7:0] REG_INT_STATUS = 8'h18;
    localparam logic [7:0] REG_INT_MASK = 8'h1c;
    localparam logic [7:0] REG_LUT_WRITE = 8'h20;
    localparam logic [7:0] REG_POP_BASE = 8'h40;
    localparam logic [7:0] REG_POP_MASK = 8'he0;
    localparam int POP_CH_LSB = 2;

    // field layouts
    localparam int LUT_LABEL_LSB = 0;
    localparam int LUT_CH_LSB = 8;
    localparam int LUT_VAL_BIT = 16;
    localparam int FLAG_SEL_W = 2 * CHANNELS;

    // reset values
    localparam logic [7:0] THRESH_VAL_RST = 8'h00;
    localparam logic [FLAG_SEL_W-1:0] FLAG_SEL_RST = 16'h0000;
    localparam logic [CHANNELS-1:0] FLAGS_RST = 8'h00;
    localparam logic [SCHEDS-1:0] FRESH_ALL = 4'hf;
    localparam logic [SCHEDS-1:0] FRESH_NONE = 4'h0;

    // per-channel flag source for the muxed flag
    typedef enum logic [1:0] {
        FFS_NOT_EMPTY = 2'h0,
        FFS_THRESH = 2'h1,
        FFS_FULL = 2'h2,
        FFS_OFF = 2'h3
    } flag_sel_t;

    // bring-up sweep, then normal running
    typedef enum logic {
        ST_SWEEP = 1'b0,
        ST_RUN = 1'b1
    } mode_t;
endpackage

// ==== design/rxlog_ram.sv ====
`timescale 1ns/10ps
`default_nettype none
module rxlog_ram #(
    parameter int WIDTH = 32,
    parameter int AW = 8
) (
    // clock
    input wire logic clk_i,
    // write port with per-bit mask
    input wire logic we_i,
    input wire logic [AW-1:0] wr_addr_i,
    input wire logic [WIDTH-1:0] wr_data_i,
    input wire logic [WIDTH-1:0] wr_mask_i,
    // registered read port
    input wire logic [AW-1:0] rd_addr_i,
    output logic [WIDTH-1:0] rd_data_o
);
    logic [WIDTH-1:0] mem [2**AW];

    // masked write, untouched bits keep their value
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            for (int i = 0; i < WIDTH; i++) begin
                if (wr_mask_i[i]) begin
                    mem[wr_addr_i][i] <= wr_data_i[i];
                end
            end
        end
    end

    // read returns the value before a same-edge write
    always_ff @(posedge clk_i) begin
        rd_data_o <= mem[rd_addr_i];
    end
endmodule
`default_nettype wire

// ==== design/rxlog_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
module rxlog_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // asynchronous in, synchronous out
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_r;

    // two flops, first one feeds only the second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_r <= '0;
            q_o <= '0;
        end else begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end
endmodule
`default_nettype wire

// ==== dv/a429_rx_log_fifo_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module a429_rx_log_fifo_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] rd;
    logic [3:0] sched_rd_i = 4'h0;
    logic [10:0] sched_addr_i = 11'h000;
    wire logic wb_ack_o, irq_o, lnk_clk_i, rx_valid_i;
    wire logic [3:0] fr;
    wire logic [31:0] wb_dat_o, rx_word_i;
    wire logic [2:0] rx_ch_i;
    int fail_count = 0;
    int n_compared = 0;

    // clock and units
    always #5 clk_i = ~clk_i;
    rxlog_link_model i_link (.lnk_clk_o(lnk_clk_i), .rx_valid_o(rx_valid_i),
        .rx_ch_o(rx_ch_i), .rx_word_o(rx_word_i));
    rxlog_fifo i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .lnk_clk_i(lnk_clk_i),
        .rx_valid_i(rx_valid_i), .rx_ch_i(rx_ch_i), .rx_word_i(rx_word_i),
        .sched_rd_i(sched_rd_i), .sched_addr_i(sched_addr_i),
        .sched0_fresh_word_o(fr[0]), .sched1_fresh_word_o(fr[1]),
        .sched2_fresh_word_o(fr[2]), .sched3_fresh_word_o(fr[3]), .irq_o(irq_o));

    // test word i, label 0x55
    function automatic logic [31:0] wd(input int i);
        return {8'(i), 16'h5a3c, 8'h55};
    endfunction

    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // classic wishbone cycle, held until ack is sampled high
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        for (n = 0; n < 3000; n++) begin
            @(posedge clk_i);
            if (wb_ack_o === 1'b1) break;
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n == 3000) begin
            fail_count++;
            print_verdict();
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    // status registers after reset
    task automatic t_reset;
        for (int i = 0; i < 4; i++) rdchk(8'(4 * i), 32'h0);
        chk(irq_o, 1'b0);
    endtask

    // bitmap picks channel and label, pop drains, flag sources
    task automatic t_accept;
        bus(1'b1, rxlog_pkg::REG_LUT_WRITE, 32'h0001_0255);
        i_link.send(3'h2, wd(0));
        i_link.send(3'h2, 32'h0000_0056);
        i_link.send(3'h3, wd(1));
        rdchk(rxlog_pkg::REG_NOT_EMPTY, 32'h4);
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, rxlog_pkg::REG_FLAG_SEL, 32'(m) << 4);
            rdchk(rxlog_pkg::REG_MUX_FLAG, (m < 2) ? 32'h4 : 32'h0);
        end
        rdchk(8'h48, wd(0));
        rdchk(8'h48, 32'h0);
        rdchk(rxlog_pkg::REG_NOT_EMPTY, 32'h0);
    endtask

    // threshold, full, overwrite and interrupt on channel 2
    task automatic t_fill;
        bus(1'b1, rxlog_pkg::REG_THRESH_VAL, 32'h3);
        bus(1'b1, rxlog_pkg::REG_FLAG_SEL, 32'h20);
        bus(1'b1, rxlog_pkg::REG_INT_STATUS, 32'hff);
        for (int i = 0; i < 33; i++) begin
            i_link.send(3'h2, wd(i));
            if (i == 2) rdchk(rxlog_pkg::REG_THRESH_FLAG, 32'h0);
            if (i == 3) rdchk(rxlog_pkg::REG_THRESH_FLAG, 32'h4);
            if (i == 30) rdchk(rxlog_pkg::REG_FULL, 32'h0);
        end
        rdchk(rxlog_pkg::REG_FULL, 32'h4);
        rdchk(rxlog_pkg::REG_INT_STATUS, 32'h4);
        chk(irq_o, 1'b0);
        bus(1'b1, rxlog_pkg::REG_INT_MASK, 32'h4);
        chk(irq_o, 1'b1);
        bus(1'b1, rxlog_pkg::REG_INT_STATUS, 32'h4);
        chk(irq_o, 1'b0);
        rdchk(8'h48, wd(1));
        rdchk(rxlog_pkg::REG_FULL, 32'h0);
        for (int j = 2; j < 33; j++) rdchk(8'h48, wd(j));
        rdchk(rxlog_pkg::REG_NOT_EMPTY, 32'h0);
        rdchk(rxlog_pkg::REG_THRESH_VAL, 32'h3);
        rdchk(rxlog_pkg::REG_FLAG_SEL, 32'h20);
        rdchk(rxlog_pkg::REG_INT_MASK, 32'h4);
        rdchk(rxlog_pkg::REG_LUT_WRITE, 32'h0);
    endtask

    // pop racing an append on channel 2, swept over the arrival cycle
    task automatic t_collide;
        for (int k = 3; k < 11; k++) begin
            i_link.send(3'h2, wd(100));
            fork
                i_link.send(3'h2, wd(k));
                begin
                    repeat (k) @(posedge clk_i);
                    rdchk(8'h48, wd(100));
                end
            join
            rdchk(8'h48, wd(k));
            rdchk(8'h48, 32'h0);
        end
    endtask

    // freshness bits set by a word, cleared per scheduler
    task automatic t_fresh;
        @(posedge clk_i);
        sched_addr_i <= 11'h255;
        repeat (2) @(posedge clk_i);
        chk(fr, 4'hf);
        sched_rd_i <= 4'h4;
        @(posedge clk_i);
        sched_rd_i <= 4'h0;
        repeat (3) @(posedge clk_i);
        chk(fr, 4'hb);
    endtask

    // main sequence
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_accept();
        t_fill();
        t_collide();
        t_fresh();
        print_verdict();
    end
endmodule
`default_nettype wire

// ==== dv/rxlog_link_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module rxlog_link_model (
    // received word link
    output logic lnk_clk_o,
    output logic rx_valid_o,
    output logic [2:0] rx_ch_o,
    output logic [31:0] rx_word_o
);
    // link idles low with no word present
    initial begin
        lnk_clk_o = 1'b0;
        rx_valid_o = 1'b0;
        rx_ch_o = 3'h0;
        rx_word_o = 32'h0;
    end

    // one word per strobe: 40 ns setup, 40 ns hold, then the lines are scrambled
    task automatic send(input logic [2:0] ch, input logic [31:0] w);
        rx_valid_o = 1'b1;
        rx_ch_o = ch;
        rx_word_o = w;
        #40 lnk_clk_o = 1'b1;
        #40 lnk_clk_o = 1'b0;
        rx_valid_o = 1'b0;
        rx_ch_o = ~ch;
        rx_word_o = ~w;
        #100;
    endtask
endmodule
`default_nettype wire
